/* rtl/ieq_pkg.sv */
// Package of constants for the instrument error queue
package ieq_pkg;

	// Register byte offsets on APB
	localparam logic [7:0]  IEQ_OFS_CTRL    = 8'h00; // W: clear-status etc.
	localparam logic [7:0]  IEQ_OFS_ERROR   = 8'h04; // R: pop oldest error
	localparam logic [7:0]  IEQ_OFS_STATUS  = 8'h08; // R: counts and flags
	localparam logic [7:0]  IEQ_OFS_ESR     = 8'h0c; // R: event status bits
	localparam logic [7:0]  IEQ_OFS_INT_ST  = 8'h10; // R: sticky events
	localparam logic [7:0]  IEQ_OFS_INT_CLR = 8'h14; // W: write 1 to clear
	localparam logic [7:0]  IEQ_OFS_INT_EN  = 8'h18; // RW: interrupt enable

	// Control register bits
	localparam int          IEQ_CTRL_CLS    = 0;     // Clear status
	localparam int          IEQ_CTRL_RST    = 1;     // Factory reset
	localparam int          IEQ_CTRL_PRESET = 2;     // Instrument preset

	// Status register field positions
	localparam int          IEQ_ST_NONEMPTY = 0;
	localparam int          IEQ_ST_OVF_IF   = 1;
	localparam int          IEQ_ST_OVF_GL   = 2;
	localparam int          IEQ_ST_CNT_IF   = 8;
	localparam int          IEQ_ST_CNT_GL   = 16;

	// Event status register bits set by error class
	localparam int          IEQ_ESR_QUERY   = 2;
	localparam int          IEQ_ESR_DEVICE  = 3;
	localparam int          IEQ_ESR_EXEC    = 4;
	localparam int          IEQ_ESR_CMD     = 5;

	// Interrupt status bits
	localparam int          IEQ_IRQ_STORED  = 0;     // Entry stored
	localparam int          IEQ_IRQ_OVF     = 1;     // Overflow marker set
	localparam int          IEQ_IRQ_DROP    = 2;     // Error discarded
	localparam int          IEQ_IRQ_W       = 3;

	// Queue geometry and error codes
	localparam int          IEQ_DEPTH       = 20;
	localparam int          IEQ_CODE_W      = 16;
	localparam logic signed [15:0] IEQ_NO_ERROR  = 16'sh0000; // +0
	localparam logic signed [15:0] IEQ_OVERFLOW  = -16'sd350;
	localparam logic signed [15:0] IEQ_CMD_LO    = -16'sd158;
	localparam logic signed [15:0] IEQ_CMD_HI    = -16'sd100;
	localparam logic signed [15:0] IEQ_EXE_LO    = -16'sd230;
	localparam logic signed [15:0] IEQ_EXE_HI    = -16'sd200;
	localparam logic signed [15:0] IEQ_QRY_INT   = -16'sd410;
	localparam logic signed [15:0] IEQ_QRY_UNT   = -16'sd420;
	localparam logic signed [15:0] IEQ_DEV_LO    = 16'sd510;
	localparam logic signed [15:0] IEQ_DEV_HI    = 16'sd540;
	localparam logic signed [15:0] IEQ_TRIP_BASE = 16'sd510; // 510..513
	localparam logic signed [15:0] IEQ_TEST_BASE = 16'sd630; // 630..647
	localparam int          IEQ_TRIPS       = 4;
	localparam int          IEQ_TESTS       = 18;

	// Bus access phases up to the answer
	typedef enum logic [1:0] {
		IEQ_PH_IDLE = 2'b00,                         // Waiting for access
		IEQ_PH_LOOK = 2'b01,                         // Queue picked
		IEQ_PH_ANS  = 2'b10                          // Answer on bus
	} ieq_phase_t;

	// Which queue a pending error read drains
	typedef enum logic [1:0] {
		IEQ_SRC_NONE = 2'b00,
		IEQ_SRC_IF   = 2'b01,
		IEQ_SRC_GL   = 2'b10
	} ieq_src_t;

endpackage : ieq_pkg

/* rtl/ieq_mem.sv */
// Storage array of one error queue, registered read port
`timescale 1ns/1ps
`default_nettype none
module ieq_mem #(
	parameter int W     = 16,                        // Word width
	parameter int DEPTH = 20,                        // Entries
	parameter int AW    = 5                          // Address width
) (
	input  wire logic          clock_i,              // Instrument clock
	input  wire logic          rst_b_i,              // Async reset, low
	input  wire logic          we_i,                 // Write strobe
	input  wire logic [AW-1:0] waddr_i,              // Write address
	input  wire logic [W-1:0]  wdata_i,              // Write data
	input  wire logic [AW-1:0] raddr_i,              // Read address
	output logic      [W-1:0]  rdata_o               // Read data, registered
);

	// Whole state of the array
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;                  // Entries
		logic [W-1:0]            rd;                   // Read register
	} ieq_mem_t;

	ieq_mem_t s_q;                                   // Current state
	ieq_mem_t s_d;                                   // Next state

	// Read sees the array before this cycle's write
	always_comb begin
		s_d    = s_q;
		s_d.rd = s_q.mem[raddr_i];
		if (we_i) begin
			s_d.mem[waddr_i] = wdata_i;
		end
	end

	// Register the state
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_o = s_q.rd;

endmodule : ieq_mem
`default_nettype wire

/* rtl/ieq_top.sv */
// Error queue of the remote-control engine with APB register access
//
// Operation
// R1 - Errors delivered oldest first
// R2 - Each read removes the delivered entry
// R3 - Interface queue drains before global queue
// R4 - Full at 20; overflow overwrites newest with -350
// R5 - After overflow discard until space freed
// R6 - Empty read returns +0, no change
// R7 - Clear-status and power cycle empty both queues
// R8 - Factory reset and preset keep queues
// R9 - Command errors set event bit 5
// R10 - Execution errors set event bit 4
// R11 - Query errors -410/-420 set event bit 2
// R12 - Device errors 510..540 set event bit 3
// R13 - Protection trips 510/511, limits 512/513
// R14 - Each failed self-test check queues own code
// R15 - Non-empty flag while either queue holds entries
`timescale 1ns/1ps
`default_nettype none
module ieq_top
	import ieq_pkg::*;
#(
	parameter int DEPTH = ieq_pkg::IEQ_DEPTH         // Entries per queue
) (
	input  wire logic        clock_i,                // 125 MHz clock
	input  wire logic        rst_b_i,                // Async reset, low
	input  wire logic        psel_i,                 // APB select
	input  wire logic        penable_i,              // APB enable
	input  wire logic        pwrite_i,               // APB direction
	input  wire logic [7:0]  paddr_i,                // APB byte address
	input  wire logic [31:0] pwdata_i,               // APB write data
	output logic      [31:0] prdata_o,               // APB read data
	output logic             pready_o,               // APB ready
	output logic             pslverr_o,              // APB error
	input  wire logic        err_push_i,             // Engine error strobe
	input  wire logic [15:0] err_code_i,             // Signed error code
	input  wire logic        err_global_i,           // 1: global queue
	input  wire logic        ovp_trip_i,             // Voltage protection
	input  wire logic        ocp_trip_i,             // Current protection
	input  wire logic        ov_limit_i,             // Voltage over limit
	input  wire logic        oc_limit_i,             // Current over limit
	input  wire logic        test_done_i,            // Self-test finished
	input  wire logic [17:0] test_fail_i,            // Failed checks
	output logic             nonempty_o,             // Some entry stored
	output logic      [7:0]  esr_o,                  // Event status bits
	output logic             irq_o                   // Level interrupt
);
	import ieq_pkg::*;

	localparam int AW = $clog2(DEPTH);               // Pointer width
	localparam int CW = $clog2(DEPTH + 1);           // Count width
	localparam int NP = IEQ_TRIPS + IEQ_TESTS;       // Pending sources

	// Pointers and counts per queue: index 0 interface, 1 global
	// A separate count instead of a wrap bit keeps the full test
	// a plain compare against the depth
	// Whole state of the block
	typedef struct packed {
		logic [1:0][AW-1:0]     head;                  // Oldest entry
		logic [1:0][AW-1:0]     tail;                  // Next free slot
		logic [1:0][CW-1:0]     cnt;                   // Stored entries
		logic [1:0]             ovf;                   // Overflow marker in
		logic [NP-1:0]          pend;                  // Waiting device errors
		logic [7:0]             esr;                   // Event status
		logic [IEQ_IRQ_W-1:0]   istat;                 // Sticky events
		logic [IEQ_IRQ_W-1:0]   ien;                   // Interrupt enable
		ieq_phase_t             phase;                 // Bus access phase
		ieq_src_t               src;                   // Queue to drain
		logic [31:0]            rdata;                 // Read data
		logic                   ready;                 // Bus ready
		logic                   slverr;                // Bus error
		logic                   nonempty;              // Non-empty flag
		logic                   irq;                   // Interrupt line
	} ieq_state_t;

	ieq_state_t s_q;                                 // Current state
	ieq_state_t s_d;                                 // Next state

	logic [1:0]           mem_we;                    // Write strobes
	logic [1:0][AW-1:0]   mem_waddr;                 // Write addresses
	logic [1:0][15:0]     mem_wdata;                 // Write data
	logic [1:0][15:0]     mem_rdata;                 // Head entries

	// Advance a pointer with wrap at the queue end
	function automatic logic [AW-1:0] ieq_next(input logic [AW-1:0] p);
		if (p == AW'(DEPTH - 1)) begin
			return '0;
		end
		return p + AW'(1);
	endfunction : ieq_next

	// Step a pointer back with wrap
	// The overflow marker lands just behind the tail, which is
	// the newest entry whenever the queue is full
	function automatic logic [AW-1:0] ieq_prev(input logic [AW-1:0] p);
		if (p == '0) begin
			return AW'(DEPTH - 1);
		end
		return p - AW'(1);
	endfunction : ieq_prev

	// Event status bits for one error code
	// A code outside every range sets nothing; the overflow marker
	// is an internal error and belongs to no class
	function automatic logic [7:0] ieq_class(input logic signed [15:0] c);
		logic [7:0] b;
		b = '0;
		if (c >= IEQ_CMD_LO && c <= IEQ_CMD_HI) begin
			b[IEQ_ESR_CMD] = 1'b1;                       // see R9
		end
		if (c >= IEQ_EXE_LO && c <= IEQ_EXE_HI) begin
			b[IEQ_ESR_EXEC] = 1'b1;                      // see R10
		end
		if (c == IEQ_QRY_INT || c == IEQ_QRY_UNT) begin
			b[IEQ_ESR_QUERY] = 1'b1;                     // see R11
		end
		if (c >= IEQ_DEV_LO && c <= IEQ_DEV_HI) begin
			b[IEQ_ESR_DEVICE] = 1'b1;                    // see R12
		end
		return b;
	endfunction : ieq_class

	// One storage array per queue; index 0 interface, 1 global
	// Reads are registered, so the head entry is valid one cycle
	// after the head pointer moves; the bus walk waits for that
	for (genvar g = 0; g < 2; g++) begin : g_q
		ieq_mem #(
			.W     (IEQ_CODE_W),
			.DEPTH (DEPTH),
			.AW    (AW)
		) u_mem (
			.clock_i (clock_i),
			.rst_b_i (rst_b_i),
			.we_i    (mem_we[g]),
			.waddr_i (mem_waddr[g]),
			.wdata_i (mem_wdata[g]),
			.raddr_i (s_q.head[g]),                      // see R1
			.rdata_o (mem_rdata[g])
		);
	end

	// Next-state logic: bus, pops, pushes, flags
	always_comb begin
		logic                 acc;                     // Access phase now
		logic                 done;                    // Transfer completes
		logic                 push_v;                  // A code to store
		logic signed [15:0]   push_c;                  // That code
		logic                 push_g;                  // Its queue
		logic [IEQ_IRQ_W-1:0] iset;                    // New events
		logic [NP-1:0]        news;                    // New device errors
		logic                 found;                   // Pending picked
		int                   qi;                      // Queue index
		acc       = psel_i && penable_i;
		done      = acc && s_q.ready;
		push_v    = 1'b0;
		push_c    = IEQ_NO_ERROR;
		push_g    = 1'b0;
		iset      = '0;
		news      = '0;
		found     = 1'b0;
		qi        = 0;
		mem_we    = '0;
		mem_waddr = '0;
		mem_wdata = '0;
		s_d       = s_q;
		s_d.ready  = 1'b0;
		s_d.slverr = 1'b0;

		// Access phase walk: pick queue, fetch head, answer
		// Queue chosen once in the first access cycle, so a later
		// push in the same transfer cannot switch the source
		if (acc && !s_q.ready) begin
			case (s_q.phase)
				IEQ_PH_IDLE: begin
					s_d.phase = IEQ_PH_LOOK;
					if (s_q.cnt[0] != '0) begin
						s_d.src = IEQ_SRC_IF;                  // see R3
					end else if (s_q.cnt[1] != '0) begin
						s_d.src = IEQ_SRC_GL;                  // see R3
					end else begin
						s_d.src = IEQ_SRC_NONE;                // see R6
					end
				end
				IEQ_PH_LOOK: begin
					// Head data is settled one cycle after the pick
					s_d.phase = IEQ_PH_ANS;
					s_d.ready = 1'b1;
					s_d.rdata = '0;
					case (paddr_i)
						IEQ_OFS_ERROR: begin
							if (pwrite_i) begin
								s_d.slverr = 1'b1;                   // Read-only
							end else if (s_q.src == IEQ_SRC_IF) begin
								s_d.rdata = {{16{mem_rdata[0][15]}}, mem_rdata[0]};
							end else if (s_q.src == IEQ_SRC_GL) begin
								s_d.rdata = {{16{mem_rdata[1][15]}}, mem_rdata[1]};
							end else begin
								s_d.rdata = 32'(IEQ_NO_ERROR);       // see R6
							end
						end
						IEQ_OFS_STATUS: begin
							s_d.rdata[IEQ_ST_NONEMPTY] = s_q.nonempty;
							s_d.rdata[IEQ_ST_OVF_IF]   = s_q.ovf[0];
							s_d.rdata[IEQ_ST_OVF_GL]   = s_q.ovf[1];
							s_d.rdata[IEQ_ST_CNT_IF +: CW] = s_q.cnt[0];
							s_d.rdata[IEQ_ST_CNT_GL +: CW] = s_q.cnt[1];
						end
						IEQ_OFS_ESR:     s_d.rdata[7:0] = s_q.esr;
						IEQ_OFS_INT_ST:  s_d.rdata[IEQ_IRQ_W-1:0] = s_q.istat;
						IEQ_OFS_INT_EN:  s_d.rdata[IEQ_IRQ_W-1:0] = s_q.ien;
						IEQ_OFS_CTRL,
						IEQ_OFS_INT_CLR: s_d.rdata = '0;     // Write-only
						default:         s_d.slverr = 1'b1;  // Unmapped
					endcase
				end
				default: begin
					s_d.phase = IEQ_PH_IDLE;
				end
			endcase
		end

		// Completion edge: writes and the pop take effect here only
		// Limitation: a transfer dropped before its answer leaves the
		// phase where it stood; the bus protocol forbids that case
		if (done) begin
			s_d.phase = IEQ_PH_IDLE;
			if (!s_q.slverr && pwrite_i) begin
				case (paddr_i)
					IEQ_OFS_CTRL: begin
						// Reset and preset bits leave both queues alone
						if (pwdata_i[IEQ_CTRL_CLS]) begin         // see R8
							s_d.head = '0;                          // see R7
							s_d.tail = '0;                          // see R7
							s_d.cnt  = '0;                          // see R7
							s_d.ovf  = '0;
							s_d.pend = '0;
							s_d.esr  = '0;
						end
					end
					IEQ_OFS_INT_CLR: begin
						s_d.istat = s_q.istat & ~pwdata_i[IEQ_IRQ_W-1:0];
					end
					IEQ_OFS_INT_EN: begin
						s_d.ien = pwdata_i[IEQ_IRQ_W-1:0];
					end
					default: begin
						s_d.ien = s_q.ien;                      // Ignored
					end
				endcase
			end
			if (!s_q.slverr && !pwrite_i && paddr_i == IEQ_OFS_ERROR
			    && s_q.src != IEQ_SRC_NONE) begin
				qi = (s_q.src == IEQ_SRC_GL) ? 1 : 0;
				s_d.head[qi] = ieq_next(s_q.head[qi]);     // see R2
				s_d.cnt[qi]  = s_q.cnt[qi] - CW'(1);       // see R2
				s_d.ovf[qi]  = 1'b0;                       // see R5
			end
		end

		// Pick one code to store: the engine first, then waiting ones
		// Device errors wait in the pending set, so none is lost
		// while the engine keeps the store busy
		if (err_push_i) begin
			push_v = 1'b1;
			push_c = err_code_i;
			push_g = err_global_i;
		end else begin
			for (int i = 0; i < NP; i++) begin
				if (s_q.pend[i] && !found) begin
					found     = 1'b1;
					push_v    = 1'b1;
					push_g    = 1'b1;
					s_d.pend[i] = 1'b0;
					if (i < IEQ_TRIPS) begin
						push_c = IEQ_TRIP_BASE + 16'(i);        // see R13
					end else begin
						push_c = IEQ_TEST_BASE + 16'(i - IEQ_TRIPS); // see R14
					end
				end
			end
		end

		// Store, mark overflow, or discard
		// Class bits are set even for a discarded code, so the host
		// still learns that such an error happened
		if (push_v) begin
			qi = push_g ? 1 : 0;
			s_d.esr = s_d.esr | ieq_class(push_c);       // see R9
			if (s_d.cnt[qi] < CW'(DEPTH)) begin
				mem_we[qi]    = 1'b1;
				mem_waddr[qi] = s_d.tail[qi];
				mem_wdata[qi] = push_c;
				s_d.tail[qi]  = ieq_next(s_d.tail[qi]);     // see R1
				s_d.cnt[qi]   = s_d.cnt[qi] + CW'(1);
				iset[IEQ_IRQ_STORED] = 1'b1;
			end else if (!s_d.ovf[qi]) begin
				mem_we[qi]    = 1'b1;
				mem_waddr[qi] = ieq_prev(s_d.tail[qi]);     // see R4
				mem_wdata[qi] = IEQ_OVERFLOW;               // see R4
				s_d.ovf[qi]   = 1'b1;
				iset[IEQ_IRQ_OVF] = 1'b1;
			end else begin
				iset[IEQ_IRQ_DROP] = 1'b1;                  // see R5
			end
		end

		// New device errors join the waiting set; set beats clear
		news[0] = ovp_trip_i;                          // see R13
		news[1] = ocp_trip_i;                          // see R13
		news[2] = ov_limit_i;                          // see R13
		news[3] = oc_limit_i;                          // see R13
		if (test_done_i) begin
			news[NP-1:IEQ_TRIPS] = test_fail_i;          // see R14
		end
		s_d.pend  = s_d.pend | news;
		s_d.istat = s_d.istat | iset;

		// Registered outputs follow the next state
		s_d.nonempty = (s_d.cnt[0] != '0) || (s_d.cnt[1] != '0); // see R15
		s_d.irq      = |(s_d.istat & s_d.ien);
	end

	// Register the state; power-up empties both queues
	// Clearing pointers and counts is enough: stale array words
	// are never read back as long as the count says empty
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;                                   // see R7
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops
	assign prdata_o   = s_q.rdata;
	assign pready_o   = s_q.ready;
	assign pslverr_o  = s_q.slverr;
	assign nonempty_o = s_q.nonempty;
	assign esr_o      = s_q.esr;
	assign irq_o      = s_q.irq;

endmodule : ieq_top
`default_nettype wire

/* test/ieq_properties.sv */
// Port-level checks of the error queue
`timescale 1ns/1ps
`default_nettype none
module ieq_properties #(
	parameter int DEPTH = 20                 // Entries per queue
) (
	input wire logic        clock_i,         // Clock
	input wire logic        rst_b_i,         // Reset, low
	input wire logic        psel_i,          // APB select
	input wire logic        penable_i,       // APB enable
	input wire logic        pready_o,        // APB ready
	input wire logic        pslverr_o,       // APB error
	input wire logic        err_push_i,      // Error strobe
	input wire logic [15:0] err_code_i,      // Error code
	input wire logic        ovp_trip_i,      // Voltage trip
	input wire logic        nonempty_o,      // Entries held
	input wire logic [7:0]  esr_o,           // Event bits
	input wire logic        irq_o            // Interrupt
);
	import ieq_pkg::*;
	// Signed view so class ranges compare as numbers
	wire logic signed [15:0] code = err_code_i;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);

	ready_wait_a: assert property ($rose(penable_i) && psel_i |->
		!pready_o ##1 !pready_o ##1 pready_o) else $error("late ready");
	ready_one_a: assert property (pready_o |=> !pready_o)
		else $error("ready held");
	err_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	cmd_bit_a: assert property (err_push_i && code inside
		{[IEQ_CMD_LO:IEQ_CMD_HI]} |=> esr_o[IEQ_ESR_CMD]) else $error("cmd");
	exec_bit_a: assert property (err_push_i && code inside
		{[IEQ_EXE_LO:IEQ_EXE_HI]} |=> esr_o[IEQ_ESR_EXEC]) else $error("exe");
	query_bit_a: assert property (err_push_i && (code == IEQ_QRY_INT ||
		code == IEQ_QRY_UNT) |=> esr_o[IEQ_ESR_QUERY]) else $error("qry");
	dev_bit_a: assert property (err_push_i && code inside
		{[IEQ_DEV_LO:IEQ_DEV_HI]} |=> esr_o[IEQ_ESR_DEVICE]) else $error("dev");
	trip_bit_a: assert property (ovp_trip_i |->
		##[1:40] esr_o[IEQ_ESR_DEVICE]) else $error("trip not queued");
	fill_flag_a: assert property (err_push_i |=> nonempty_o)
		else $error("flag low after push");

	// Main scenarios reached
	cover property (pready_o && pslverr_o);
	cover property (err_push_i && nonempty_o);
	cover property ($rose(irq_o));
endmodule : ieq_properties
`default_nettype wire

/* test/ieq_host.sv */
// Remote host model: APB master reading the queue
`timescale 1ns/1ps
`default_nettype none
module ieq_host (
	input  wire logic        clock_i,        // Clock
	output logic             psel_o,         // Select
	output logic             penable_o,      // Enable
	output logic             pwrite_o,       // Direction
	output logic      [7:0]  paddr_o,        // Byte address
	output logic      [31:0] pwdata_o,       // Write data
	input  wire logic [31:0] prdata_i,       // Read data
	input  wire logic        pready_i,       // Ready
	input  wire logic        pslverr_i       // Error
);
	// Idle bus at time zero
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0;
	end

	// One transfer; waits for ready, the bench watchdog ends a hang
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clock_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clock_i);
		penable_o <= 1'b1;
		do begin
			@(posedge clock_i);
		end while (pready_i !== 1'b1);
		r = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// Released bus flips so stale values never look valid
		pwrite_o <= ~w;
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask : xfer
endmodule : ieq_host
`default_nettype wire

/* test/ieq_top_test.sv */
// Self-checking bench of the error queue with a queue model
`timescale 1ns/1ps
`default_nettype none
module ieq_top_test;
	import ieq_pkg::*;
	localparam int DEPTH = 20;               // Entries per queue
	logic        clock_i = 1'b0;             // Clock
	logic        rst_b_i = 1'b0;             // Reset, low
	logic        psel, penable, pwrite;      // APB controls
	logic [7:0]  paddr;                      // APB address
	logic [31:0] pwdata, prdata, r;          // APB data
	logic        pready, pslverr, e;         // APB answer
	logic        push = 0, glob = 0;         // Error strobe, queue
	logic [15:0] code = 0;                   // Error code
	logic [3:0]  trip = 0;                   // Protection pulses
	logic        tdone = 0;                  // Self-test done
	logic [17:0] tfail = 0;                  // Failed checks
	logic        nonempty, irq;              // Flags
	logic [7:0]  esr;                        // Event bits
	int          error_cnt = 0;              // Mismatches
	int          comparisons = 0;            // Checks made
	int          qif[$], qgl[$];             // Model queues
	bit          oif, ogl;                   // Model overflow flags
	logic [7:0]  esr_m = 0;                  // Model event bits
	int          tbl[9] = '{-102, -158, -100, -211, -230, -410, -420,
		540, 521};                           // Codes of all classes

	always #4 clock_i = ~clock_i;

	ieq_host host (.clock_i(clock_i), .psel_o(psel), .penable_o(penable),
		.pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
		.prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
	ieq_top #(.DEPTH(DEPTH)) dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .err_push_i(push),
		.err_code_i(code), .err_global_i(glob), .ovp_trip_i(trip[0]),
		.ocp_trip_i(trip[1]), .ov_limit_i(trip[2]), .oc_limit_i(trip[3]),
		.test_done_i(tdone), .test_fail_i(tfail), .nonempty_o(nonempty),
		.esr_o(esr), .irq_o(irq));

	// Class bit of a code
	function automatic logic [7:0] cls(input int c);
		cls = 8'h00;
		if (c >= -158 && c <= -100) cls[IEQ_ESR_CMD] = 1'b1;
		if (c >= -230 && c <= -200) cls[IEQ_ESR_EXEC] = 1'b1;
		if (c == -410 || c == -420) cls[IEQ_ESR_QUERY] = 1'b1;
		if (c >= 510 && c <= 540) cls[IEQ_ESR_DEVICE] = 1'b1;
	endfunction : cls

	// Model store: full queue takes one overflow mark, then drops
	task automatic put(ref int q[$], ref bit o, input int c);
		esr_m |= cls(c);
		if (q.size() < DEPTH) q.push_back(c);
		else if (!o) begin
			q[q.size()-1] = -350;
			o = 1'b1;
		end
	endtask : put

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		host.xfer(a, 1'b0, 32'h0, r, e);
		chk(r, exp);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(a, 1'b1, d, r, e);
	endtask : wr

	task automatic add(input int c, input bit g);
		@(posedge clock_i);
		push <= 1'b1;
		code <= 16'(c);
		glob <= g;
		@(posedge clock_i);
		push <= 1'b0;
		code <= ~16'(c);
		if (g) put(qgl, ogl, c);
		else put(qif, oif, c);
	endtask : add

	// Pop expected from interface queue first, then global
	task automatic pop_chk();
		int x;
		x = 0;
		if (qif.size() > 0) begin
			x = qif.pop_front();
			oif = 1'b0;
		end else if (qgl.size() > 0) begin
			x = qgl.pop_front();
			ogl = 1'b0;
		end
		rd(IEQ_OFS_ERROR, x);
	endtask : pop_chk

	task automatic st();
		rd(IEQ_OFS_STATUS, {11'h0, 5'(qgl.size()), 3'h0, 5'(qif.size()),
			5'h0, ogl, oif, 1'(qif.size() + qgl.size() > 0)});
		rd(IEQ_OFS_ESR, {24'h0, esr_m});
		chk({24'h0, esr}, {24'h0, esr_m});
		chk(32'(nonempty), 32'(qif.size() + qgl.size() > 0));
	endtask : st

	task automatic irq_chk(input logic x);
		repeat (2) @(posedge clock_i);
		chk(32'(irq), 32'(x));
	endtask : irq_chk

	task automatic test_done();
		$display("checks %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	// Watchdog well beyond the expected run
	initial begin
		#(8 * 20000);
		error_cnt++;
		test_done();
	end

	// Main sequence
	initial begin
		void'($urandom(15139));
		repeat (6) @(posedge clock_i);
		rst_b_i <= 1'b1;
		st();
		pop_chk();
		st();
		for (int i = 0; i < 12; i++) add(tbl[$urandom_range(8)], 1'($urandom));
		st();
		repeat (13) pop_chk();
		for (int i = 0; i < 23; i++) add(tbl[$urandom_range(8)], 1'b1);
		st();
		pop_chk();
		add(-113, 1'b1);
		st();
		repeat (21) pop_chk();
		add(-102, 1'b0);
		add(533, 1'b1);
		wr(IEQ_OFS_CTRL, 32'h1 << IEQ_CTRL_RST);
		wr(IEQ_OFS_CTRL, 32'h1 << IEQ_CTRL_PRESET);
		st();
		wr(IEQ_OFS_CTRL, 32'h1 << IEQ_CTRL_CLS);
		qif.delete();
		qgl.delete();
		esr_m = 8'h00;
		st();
		@(posedge clock_i);
		trip <= 4'hf;
		tdone <= 1'b1;
		tfail <= 18'($urandom);
		@(posedge clock_i);
		trip <= 4'h0;
		tdone <= 1'b0;
		for (int k = 0; k < 4; k++) put(qgl, ogl, 510 + k);
		for (int k = 0; k < 18; k++) if (tfail[k]) put(qgl, ogl, 630 + k);
		tfail <= ~tfail;
		repeat (30) @(posedge clock_i);
		st();
		repeat (21) pop_chk();
		wr(IEQ_OFS_INT_CLR, 32'h7);
		wr(IEQ_OFS_INT_EN, 32'h7);
		irq_chk(1'b0);
		add(-220, 1'b0);
		irq_chk(1'b1);
		rd(IEQ_OFS_INT_ST, 32'h1);
		wr(IEQ_OFS_INT_EN, 32'h0);
		irq_chk(1'b0);
		wr(IEQ_OFS_INT_EN, 32'h1);
		wr(IEQ_OFS_INT_CLR, 32'h1);
		irq_chk(1'b0);
		wr(IEQ_OFS_ERROR, 32'h0);
		chk(32'(e), 32'h1);
		st();
		rd(8'h1c, 32'h0);
		chk(32'(e), 32'h1);
		pop_chk();
		add(-410, 1'b1);
		st();
		@(posedge clock_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		rst_b_i <= 1'b1;
		qgl.delete();
		esr_m = 8'h00;
		st();
		test_done();
	end
endmodule : ieq_top_test

bind ieq_top ieq_properties #(.DEPTH(DEPTH)) chk_i (.clock_i(clock_i),
	.rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .err_push_i(err_push_i),
	.err_code_i(err_code_i), .ovp_trip_i(ovp_trip_i),
	.nonempty_o(nonempty_o), .esr_o(esr_o), .irq_o(irq_o));
`default_nettype wire
